// File: core/rbp_port.sv
// Bytewide register port with 64 byte registers, time keeping core,
// time-of-day alarm, watchdog and supply write protection.
// Assumes bus strobes and supply indications are synchronous to ref_clk.
// Function
// - Read when CE, OE low, WE high
// - Six address bits pick one of 64
// - CE and WE low means write
// - Write starts at later falling strobe
// - Write ends, data captured, first rising strobe
// - Falling WE turns read drivers off
// - Supply failure blocks all bus access
// - Interrupts and time run on any supply
// - Active-high second interrupt only with supply
// - Write protect until supply good for delay
// - Time and calendar registers are BCD
// - Alarm registers 3, 5, 7 are BCD
// - Register B is binary command register
// - Watchdog interval registers C, D are BCD
// - Locations E to 3F are user bytes
// - Visible copy refreshed from internal copy
// - Command register set by host and events
// - Refresh every hundredth unless frozen or stopped
// - Advance at 99, copy at roll to 00
module rbp_port #(
    parameter int unsigned TICK_CYC   = rbp_pkg::TICK_CYC,
    parameter int unsigned RESUME_CYC = rbp_pkg::RESUME_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic [5:0] reg_addr_in,
    input  wire logic       ce_n,
    input  wire logic       oe_n,
    input  wire logic       we_n,
    input  wire logic [7:0] bidir_byte_bus_in,
    output logic      [7:0] bidir_byte_bus_out,
    output logic            bidir_byte_bus_oe_n,
    input  wire logic       supply_fail,
    input  wire logic       supply_ok,
    output logic            irq_out_first_out,
    output logic            irq_out_first_oe_n,
    output logic            irq_out_second_out,
    output logic            irq_out_second_oe_n
);
    localparam logic [rbp_pkg::CNT_W-1:0] TICK_LAST = rbp_pkg::CNT_W'(TICK_CYC - 1);
    localparam logic [rbp_pkg::CNT_W-1:0] RES_DONE  = rbp_pkg::CNT_W'(RESUME_CYC);

    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] max);
        logic [8:0] r;
        r = {1'b0, v[7:4], v[3:0] + 4'h1};
        if (v == max) begin
            r = {1'b1, 8'h00};
        end else if (v[3:0] == 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction

    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (b) begin
                if (r[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Bus group
    logic                        wr_act_reg;
    logic                        wr_act_next;
    rbp_pkg::rbp_wr_t            wr_lat_reg;
    rbp_pkg::rbp_wr_t            wr_lat_next;
    logic                        rd_oe_n_reg;
    logic                        rd_oe_n_next;
    logic [7:0]                  rd_data_reg;
    logic [7:0]                  rd_data_next;
    logic [rbp_pkg::CNT_W-1:0]   tick_cnt_reg;
    logic [rbp_pkg::CNT_W-1:0]   tick_cnt_next;
    logic [rbp_pkg::CNT_W-1:0]   res_cnt_reg;
    logic [rbp_pkg::CNT_W-1:0]   res_cnt_next;
    // Register group
    logic [7:0]                  mem_reg  [rbp_pkg::NUM_REGS];
    logic [7:0]                  mem_next [rbp_pkg::NUM_REGS];
    rbp_pkg::rbp_time_t          t_reg;
    rbp_pkg::rbp_time_t          t_next;
    logic [15:0]                 wd_reg;
    logic [15:0]                 wd_next;

    logic                        prot;
    logic                        rd_req;
    logic                        wr_on;
    logic                        commit;
    logic                        tick;
    logic                        run;
    logic                        te;
    logic [7:0]                  cmd;

    // Protection also drops reads, so the data bus is not driven while supply is marginal
    assign prot   = supply_fail || (res_cnt_reg != RES_DONE);
    assign rd_req = !prot && !ce_n && !oe_n && we_n;
    assign wr_on  = !prot && !ce_n && !we_n;
    assign commit = wr_act_reg && !wr_on && !prot;
    assign tick   = (tick_cnt_reg == TICK_LAST);
    assign cmd    = mem_reg[rbp_pkg::A_CMD];
    assign te     = cmd[rbp_pkg::CMD_TE];
    assign run    = !mem_reg[rbp_pkg::A_MONTH][rbp_pkg::EOSC_BIT];

    always_comb begin
        wr_act_next   = wr_on;
        wr_lat_next   = wr_lat_reg;
        rd_oe_n_next  = !rd_req;
        rd_data_next  = rd_data_reg;
        tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
        res_cnt_next  = res_cnt_reg;
        // Sampled every active cycle; the last sample before a strobe rises wins
        if (wr_on) begin
            wr_lat_next = '{addr: reg_addr_in, data: bidir_byte_bus_in};
        end
        if (rd_req) begin
            rd_data_next = mem_reg[reg_addr_in];
        end
        if (supply_fail || !supply_ok) begin
            res_cnt_next = '0;
        end else if (res_cnt_reg != RES_DONE) begin
            res_cnt_next = res_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_act_reg   <= 1'b0;
            wr_lat_reg   <= '0;
            rd_oe_n_reg  <= 1'b1;
            rd_data_reg  <= 8'h00;
            tick_cnt_reg <= '0;
            res_cnt_reg  <= '0;
        end else if (clk_en) begin
            wr_act_reg   <= wr_act_next;
            wr_lat_reg   <= wr_lat_next;
            rd_oe_n_reg  <= rd_oe_n_next;
            rd_data_reg  <= rd_data_next;
            tick_cnt_reg <= tick_cnt_next;
            res_cnt_reg  <= res_cnt_next;
        end
    end

    assign bidir_byte_bus_out  = rd_data_reg;
    assign bidir_byte_bus_oe_n = rd_oe_n_reg;

    always_comb begin
        logic [8:0]  inc;
        logic        sec_roll;
        logic        tdf_set;
        logic        tdf_clr;
        logic        waf_set;
        logic        waf_clr;
        logic        wd_load;
        logic [15:0] wd_cfg;
        logic [7:0]  d;
        logic [5:0]  a;
        inc      = '0;
        sec_roll = 1'b0;
        tdf_set  = 1'b0;
        tdf_clr  = 1'b0;
        waf_set  = 1'b0;
        waf_clr  = 1'b0;
        wd_load  = 1'b0;
        d        = wr_lat_reg.data;
        a        = wr_lat_reg.addr;
        mem_next = mem_reg;
        t_next   = t_reg;
        wd_next  = wd_reg;
        wd_cfg   = {mem_reg[rbp_pkg::A_WDH], mem_reg[rbp_pkg::A_WDL]};
        // Internal copy keeps counting even while the visible copy is frozen
        if (tick && run) begin
            inc = bcd_inc(t_reg.hs, rbp_pkg::MAX_HSEC);
            t_next.hs = inc[7:0];
            if (inc[8]) begin
                inc = bcd_inc(t_reg.sec, rbp_pkg::MAX_SEC);
                t_next.sec = inc[7:0];
                sec_roll = inc[8];
                if (inc[8]) begin
                    inc = bcd_inc(t_reg.min, rbp_pkg::MAX_SEC);
                    t_next.min = inc[7:0];
                    if (inc[8]) begin
                        inc = bcd_inc(t_reg.hr, rbp_pkg::MAX_HOUR);
                        t_next.hr = inc[7:0];
                    end
                end
            end
            if (te) begin
                mem_next[rbp_pkg::A_HSEC] = t_next.hs;
                if (t_reg.hs == rbp_pkg::MAX_HSEC) begin
                    mem_next[rbp_pkg::A_SEC]  = t_next.sec;
                    mem_next[rbp_pkg::A_MIN]  = t_next.min;
                    mem_next[rbp_pkg::A_HOUR] = t_next.hr;
                end
            end
            // Alarm compares the new minute against masked BCD settings
            if (sec_roll) begin
                tdf_set = (mem_reg[rbp_pkg::A_AMIN][rbp_pkg::AMASK]
                           || mem_reg[rbp_pkg::A_AMIN][6:0] == t_next.min[6:0])
                       && (mem_reg[rbp_pkg::A_AHOUR][rbp_pkg::AMASK]
                           || mem_reg[rbp_pkg::A_AHOUR][5:0] == t_next.hr[5:0])
                       && (mem_reg[rbp_pkg::A_ADAY][rbp_pkg::AMASK]
                           || mem_reg[rbp_pkg::A_ADAY][2:0] == mem_reg[rbp_pkg::A_DAY][2:0]);
            end
            // A zero interval disables the watchdog; expiry reloads for repeat alarms
            if (wd_cfg != 16'h0000) begin
                if (wd_reg <= rbp_pkg::WD_LAST) begin
                    waf_set = 1'b1;
                    wd_next = wd_cfg;
                end else begin
                    wd_next = bcd_dec(wd_reg);
                end
            end
        end
        if (commit) begin
            mem_next[a] = d;
            case (a)
                rbp_pkg::A_HSEC: t_next.hs  = d;
                rbp_pkg::A_SEC:  t_next.sec = d;
                rbp_pkg::A_MIN:  t_next.min = d;
                rbp_pkg::A_HOUR: t_next.hr  = d;
                rbp_pkg::A_AMIN, rbp_pkg::A_AHOUR: tdf_clr = 1'b1;
                rbp_pkg::A_ADAY: begin
                    mem_next[a] = d & rbp_pkg::ADAY_KEEP;
                    tdf_clr = 1'b1;
                end
                // Flag bits are read only for the host
                rbp_pkg::A_CMD: mem_next[a] = {d[7:2], cmd[1:0]};
                rbp_pkg::A_WDL, rbp_pkg::A_WDH: begin
                    waf_clr = 1'b1;
                    wd_load = 1'b1;
                end
                default: ;
            endcase
        end
        if (rd_req) begin
            case (reg_addr_in)
                rbp_pkg::A_AMIN, rbp_pkg::A_AHOUR, rbp_pkg::A_ADAY: tdf_clr = 1'b1;
                rbp_pkg::A_WDL, rbp_pkg::A_WDH: begin
                    waf_clr = 1'b1;
                    wd_load = 1'b1;
                end
                default: ;
            endcase
        end
        if (wd_load) begin
            wd_next = {mem_next[rbp_pkg::A_WDH], mem_next[rbp_pkg::A_WDL]};
        end
        // An event in the same cycle as its clear keeps the flag set
        mem_next[rbp_pkg::A_CMD][rbp_pkg::CMD_TDF] =
            tdf_set || (cmd[rbp_pkg::CMD_TDF] && !tdf_clr);
        mem_next[rbp_pkg::A_CMD][rbp_pkg::CMD_WAF] =
            waf_set || (cmd[rbp_pkg::CMD_WAF] && !waf_clr);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < rbp_pkg::NUM_REGS; i++) begin
                mem_reg[i] <= rbp_pkg::REG_RST;
            end
            mem_reg[rbp_pkg::A_CMD] <= rbp_pkg::CMD_RST;
            t_reg  <= '0;
            wd_reg <= 16'h0000;
        end else if (clk_en) begin
            mem_reg <= mem_next;
            t_reg   <= t_next;
            wd_reg  <= wd_next;
        end
    end

    // Interrupt pins ignore protection so alarms reach a failing host, except the active-high second pin, which also needs supply_ok
    logic tod_irq;
    logic wd_irq;
    logic b_high;
    assign tod_irq = cmd[rbp_pkg::CMD_TDF] && !cmd[rbp_pkg::CMD_TDM];
    assign wd_irq  = cmd[rbp_pkg::CMD_WAF] && !cmd[rbp_pkg::CMD_WAM];
    assign b_high  = cmd[rbp_pkg::CMD_B_HI];
    assign irq_out_first_out   = 1'b0;
    assign irq_out_first_oe_n  = !tod_irq;
    assign irq_out_second_out  = b_high;
    assign irq_out_second_oe_n = b_high ? !(wd_irq && supply_ok) : !wd_irq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    logic [7:0] rd_peek;
    assign rd_peek = mem_reg[reg_addr_in];

    AST_READ_DRIVE: assert property (rd_req |=> !bidir_byte_bus_oe_n
        && bidir_byte_bus_out == $past(rd_peek))
        else $error("read data not driven");
    AST_IDLE_HIZ: assert property (!rd_req |=> bidir_byte_bus_oe_n)
        else $error("bus driven outside read");
    AST_WE_OFF: assert property ($fell(we_n) |=> bidir_byte_bus_oe_n)
        else $error("drivers stay on after write strobe");
    AST_WR_START: assert property (wr_on ##1 wr_on |-> wr_act_reg)
        else $error("write not started");
    AST_WR_COMMIT: assert property (commit && wr_lat_reg.addr >= rbp_pkg::A_RAM
        |=> mem_reg[$past(wr_lat_reg.addr)] == $past(wr_lat_reg.data))
        else $error("user byte not stored");
    AST_PROT_BLOCK: assert property (prot |-> !commit && !rd_req)
        else $error("access while protected");
    AST_RESUME: assert property ($rose(supply_ok) |-> prot [*8])
        else $error("resume delay too short");
    AST_TE_FREEZE: assert property (!te && !commit |=>
        mem_reg[rbp_pkg::A_HSEC] == $past(mem_reg[rbp_pkg::A_HSEC]))
        else $error("frozen copy changed");
    AST_ROLL: assert property (tick && run && te && !commit
        && t_reg.hs == rbp_pkg::MAX_HSEC |=> mem_reg[rbp_pkg::A_HSEC] == 8'h00
        && mem_reg[rbp_pkg::A_SEC] == t_reg.sec)
        else $error("roll copy wrong");
    AST_CMD_WRITE: assert property (commit && wr_lat_reg.addr == rbp_pkg::A_CMD
        |=> cmd[rbp_pkg::CMD_TE] == $past(wr_lat_reg.data[rbp_pkg::CMD_TE]))
        else $error("command write lost");
    AST_IRQ_OUT_SECOND_SUPPLY: assert property (!supply_ok && b_high
        |-> irq_out_second_oe_n)
        else $error("second interrupt high without supply");
    AST_IRQ_OUT_SECOND_HIGH: assert property (b_high && wd_irq && supply_ok
        |-> !irq_out_second_oe_n && irq_out_second_out)
        else $error("second interrupt not driven high");

    // Flags set only on a tick and clear on reads or alarm and watchdog writes, so a tick-free, read-free cycle isolates the host write
    AST_FLAG_RO: assert property (commit && wr_lat_reg.addr == rbp_pkg::A_CMD
        && !tick && !rd_req |=> cmd[1:0] == $past(cmd[1:0]))
        else $error("host write changed a flag");
    AST_ADAY_ZERO: assert property (mem_reg[rbp_pkg::A_ADAY][6:3] == 4'h0)
        else $error("unused alarm bits set");
    AST_TDF_CLR: assert property (rd_req && reg_addr_in == rbp_pkg::A_AMIN && !tick
        |=> !cmd[rbp_pkg::CMD_TDF])
        else $error("alarm read left flag set");
    AST_WAF_SET: assert property (tick && run && wd_reg <= rbp_pkg::WD_LAST
        && {mem_reg[rbp_pkg::A_WDH], mem_reg[rbp_pkg::A_WDL]} != 16'h0000
        |=> cmd[rbp_pkg::CMD_WAF])
        else $error("watchdog expiry not flagged");
    AST_IRQ_FIRST: assert property (tod_irq
        |-> !irq_out_first_oe_n && !irq_out_first_out)
        else $error("first interrupt not driven");
    // Time keeps counting behind protection; battery backup relies on it
    AST_TIME_RUNS: assert property (tick && run && !commit
        |=> t_reg.hs != $past(t_reg.hs))
        else $error("internal time stalled");
    // The neighbour byte shows that decoding selects a single location
    AST_ONE_REG: assert property (commit && wr_lat_reg.addr >= rbp_pkg::A_RAM
        |=> mem_reg[$past(wr_lat_reg.addr) ^ 6'h01] == $past(mem_reg[wr_lat_reg.addr ^ 6'h01]))
        else $error("write reached a second byte");
    // Protection must keep user bytes, not only refuse the strobes
    AST_PROT_KEEP: assert property (prot && reg_addr_in >= rbp_pkg::A_RAM
        |=> mem_reg[$past(reg_addr_in)] == $past(rd_peek))
        else $error("byte changed while protected");

    COV_READ: cover property (rd_req ##1 rd_req);
    COV_WRITE: cover property (commit && wr_lat_reg.addr == rbp_pkg::A_CMD);
    COV_WD_FLAG: cover property ($rose(cmd[rbp_pkg::CMD_WAF]));
    COV_RESUME: cover property ($fell(prot));
    COV_TOD_FLAG: cover property ($rose(cmd[rbp_pkg::CMD_TDF]));
endmodule

// File: core/rbp_pkg.sv
// Constants and carrier types for the bytewide register port.
// Assumes one 125 MHz core clock and bus pins already synchronous to it.
package rbp_pkg;
    localparam int unsigned CLK_HZ     = 125_000_000;
    localparam int unsigned TICK_HZ    = 100;
    localparam int unsigned TICK_CYC   = CLK_HZ / TICK_HZ;
    localparam int unsigned RESUME_MS  = 150;
    localparam int unsigned RESUME_CYC = RESUME_MS * (CLK_HZ / 1000);
    localparam int          CNT_W      = 25;
    localparam int          ADDR_W     = 6;
    localparam int          NUM_REGS   = 64;

    localparam logic [5:0] A_HSEC  = 6'h00;
    localparam logic [5:0] A_SEC   = 6'h01;
    localparam logic [5:0] A_MIN   = 6'h02;
    localparam logic [5:0] A_AMIN  = 6'h03;
    localparam logic [5:0] A_HOUR  = 6'h04;
    localparam logic [5:0] A_AHOUR = 6'h05;
    localparam logic [5:0] A_DAY   = 6'h06;
    localparam logic [5:0] A_ADAY  = 6'h07;
    localparam logic [5:0] A_MONTH = 6'h09;
    localparam logic [5:0] A_YEAR  = 6'h0A;
    localparam logic [5:0] A_CMD   = 6'h0B;
    localparam logic [5:0] A_WDL   = 6'h0C;
    localparam logic [5:0] A_WDH   = 6'h0D;
    localparam logic [5:0] A_RAM   = 6'h0E;

    localparam int CMD_TDF  = 0;
    localparam int CMD_WAF  = 1;
    localparam int CMD_TDM  = 2;
    localparam int CMD_WAM  = 3;
    localparam int CMD_B_HI = 5;
    localparam int CMD_TE   = 7;
    localparam int EOSC_BIT = 7;
    localparam int AMASK    = 7;

    localparam logic [7:0]  CMD_RST   = 8'h8C;
    localparam logic [7:0]  REG_RST   = 8'h00;
    localparam logic [7:0]  ADAY_KEEP = 8'h87;
    localparam logic [7:0]  MAX_HSEC  = 8'h99;
    localparam logic [7:0]  MAX_SEC   = 8'h59;
    localparam logic [7:0]  MAX_HOUR  = 8'h23;
    localparam logic [15:0] WD_LAST   = 16'h0001;

    typedef struct packed {
        logic [7:0] hs;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
    } rbp_time_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } rbp_wr_t;
endpackage

// File: sim/rbp_host.sv
// Host model: drives strobes, address and data of the bytewide register bus.
// Assumes the bench resolves the shared data wire from host and device drivers.
module rbp_host (
    input  wire logic       ref_clk,
    input  wire logic [7:0] bus,
    input  wire logic       dev_oe_n,
    output logic      [5:0] addr,
    output logic            ce_n,
    output logic            oe_n,
    output logic            we_n,
    output logic      [7:0] dat
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        addr = 6'h00;
        dat  = 8'h00;
    end

    // One bus step, changed at the falling edge and held over the next rising edge
    task automatic step(input logic c, input logic o, input logic w, input logic [5:0] a,
                        input logic [7:0] d, input logic drv);
        @(negedge ref_clk);
        ce_n = c;
        oe_n = o;
        we_n = w;
        addr = a;
        // Released data shows the inverse so no stale byte can pass as a match
        dat  = drv ? d : ~dat;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        step(1'b0, 1'b1, 1'b0, a, d, 1'b1);
        step(1'b1, 1'b1, 1'b1, a, d, 1'b1);
        step(1'b1, 1'b1, 1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] q, output logic oen);
        step(1'b0, 1'b0, 1'b1, a, 8'h00, 1'b0);
        @(negedge ref_clk);
        q    = bus;
        oen  = dev_oe_n;
        ce_n = 1'b1;
        oe_n = 1'b1;
    endtask
endmodule

// File: sim/rbp_port_tb.sv
// Self-checking bench for the bytewide register port.
// Assumes the host model above; short tick and resume counts keep the run brief.
module rbp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK   = 200;
    localparam int RESUME = 16;
    localparam int LIMIT  = 20000;
    typedef struct packed {
        logic [5:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } rbp_row_t;

    logic       ref_clk, rst_n, supply_fail, supply_ok, ce_n, oe_n, we_n, doe_n, oen;
    logic       irq1, irq1_oe_n, irq2, irq2_oe_n;
    logic [5:0] addr;
    logic [7:0] hdat, dout, bus, q, v1;
    int         fail_count, tests_run, cycles;
    rbp_row_t   rows [8] = '{'{6'h0E, 8'h5A, 8'h5A}, '{6'h3F, 8'hA5, 8'hA5},
                             '{6'h20, 8'hFF, 8'hFF}, '{6'h03, 8'h45, 8'h45},
                             '{6'h07, 8'hFF, 8'h87}, '{6'h0C, 8'h00, 8'h00},
                             '{6'h0D, 8'h00, 8'h00}, '{6'h1F, 8'h01, 8'h01}};

    assign bus = doe_n ? hdat : dout;

    rbp_port #(.TICK_CYC(TICK), .RESUME_CYC(RESUME)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr_in(addr),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .bidir_byte_bus_in(bus),
        .bidir_byte_bus_out(dout), .bidir_byte_bus_oe_n(doe_n),
        .supply_fail(supply_fail), .supply_ok(supply_ok),
        .irq_out_first_out(irq1), .irq_out_first_oe_n(irq1_oe_n),
        .irq_out_second_out(irq2), .irq_out_second_oe_n(irq2_oe_n));

    rbp_host host (.ref_clk(ref_clk), .bus(bus), .dev_oe_n(doe_n), .addr(addr),
                   .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dat(hdat));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Hang guard: far above the fewer than two thousand cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        rst_n = 1'b0;
        supply_fail = 1'b0;
        supply_ok = 1'b0;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        host.rd(6'h0E, q, oen);
        chk({7'h00, oen}, 8'h01);
        supply_ok = 1'b1;
        repeat (RESUME + 4) @(negedge ref_clk);
        host.rd(6'h0B, q, oen);
        chk(q, 8'h8C);
        chk({6'h00, irq1_oe_n, irq2_oe_n}, 8'h03);
        foreach (rows[i]) host.wr(rows[i].a, rows[i].d);
        foreach (rows[i]) begin
            host.rd(rows[i].a, q, oen);
            chk(q, rows[i].e);
            chk({7'h00, oen}, 8'h00);
        end
        @(negedge ref_clk);
        chk({7'h00, doe_n}, 8'h01);
        // Write enable falls first and rises last: chip enable frames the write
        host.step(1'b1, 1'b1, 1'b0, 6'h11, 8'hA1, 1'b1);
        host.step(1'b0, 1'b1, 1'b0, 6'h11, 8'hA1, 1'b1);
        host.step(1'b0, 1'b1, 1'b0, 6'h11, 8'hB2, 1'b1);
        host.step(1'b1, 1'b1, 1'b0, 6'h11, 8'hC3, 1'b1);
        host.step(1'b1, 1'b1, 1'b1, 6'h11, 8'hC3, 1'b1);
        host.step(1'b1, 1'b1, 1'b1, 6'h11, 8'h00, 1'b0);
        host.rd(6'h11, q, oen);
        chk(q, 8'hB2);
        // Write enable falls in the middle of a read
        host.step(1'b0, 1'b0, 1'b1, 6'h12, 8'h00, 1'b0);
        host.step(1'b0, 1'b0, 1'b0, 6'h12, 8'h3C, 1'b1);
        chk({7'h00, doe_n}, 8'h00);
        @(negedge ref_clk);
        chk({7'h00, doe_n}, 8'h01);
        host.step(1'b1, 1'b1, 1'b1, 6'h12, 8'h00, 1'b0);
        // Supply failure: bus ignored, then protection lasts the resume delay
        supply_fail = 1'b1;
        supply_ok = 1'b0;
        host.wr(6'h10, 8'h55);
        host.rd(6'h10, q, oen);
        chk({7'h00, oen}, 8'h01);
        supply_fail = 1'b0;
        supply_ok = 1'b1;
        host.rd(6'h10, q, oen);
        chk({7'h00, oen}, 8'h01);
        repeat (RESUME + 4) @(negedge ref_clk);
        host.rd(6'h10, q, oen);
        chk(q, 8'h00);
        // Hundredths roll from 99 to 00 and carry into seconds
        host.wr(6'h00, 8'h98);
        repeat (2 * TICK + 10) @(negedge ref_clk);
        host.rd(6'h01, q, oen);
        chk(q, 8'h01);
        host.wr(6'h0B, 8'h0F);
        host.rd(6'h0B, q, oen);
        chk(q, 8'h0C);
        host.rd(6'h00, v1, oen);
        repeat (2 * TICK) @(negedge ref_clk);
        host.rd(6'h00, q, oen);
        chk(q, v1);
        host.wr(6'h0B, 8'h8C);
        repeat (TICK + 10) @(negedge ref_clk);
        host.rd(6'h00, q, oen);
        chk({7'h00, q !== v1}, 8'h01);
        // Alarm and watchdog events drive both interrupt pins
        host.wr(6'h0B, 8'hA0);
        host.wr(6'h03, 8'h80);
        host.wr(6'h0C, 8'h02);
        host.wr(6'h01, 8'h59);
        host.wr(6'h00, 8'h98);
        repeat (3 * TICK) @(negedge ref_clk);
        chk({4'h0, irq1, irq1_oe_n, irq2, irq2_oe_n}, 8'h02);
        host.rd(6'h0B, q, oen);
        chk(q, 8'hA3);
        // Pins keep signalling without supply, but the high level needs it
        supply_fail = 1'b1;
        supply_ok = 1'b0;
        @(negedge ref_clk);
        chk({4'h0, irq1, irq1_oe_n, irq2, irq2_oe_n}, 8'h03);
        host.rd(6'h03, q, oen);
        chk({7'h00, irq1_oe_n}, 8'h00);
        supply_fail = 1'b0;
        supply_ok = 1'b1;
        repeat (RESUME + 4) @(negedge ref_clk);
        host.rd(6'h03, q, oen);
        chk(q, 8'h80);
        chk({7'h00, irq1_oe_n}, 8'h01);
        // Reset in mid-run restores the command byte and restarts protection
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        chk({7'h00, doe_n}, 8'h01);
        host.rd(6'h0E, q, oen);
        chk({7'h00, oen}, 8'h01);
        repeat (RESUME + 4) @(negedge ref_clk);
        host.rd(6'h0B, q, oen);
        chk(q, 8'h8C);
        chk({4'h0, irq1, irq1_oe_n, irq2, irq2_oe_n}, 8'h05);
        host.rd(6'h0E, q, oen);
        chk(q, 8'h00);
        summarize();
    end
endmodule
